// File: ecsb_pkg.sv
// Constants, types and decode map for the external chip-select bus.
// Assumes a single core clock at 20 MHz; bus clock is half of it.
package ecsb_pkg;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WS_W = 4;
    localparam int unsigned NSEL = 5;
    localparam logic [WS_W-1:0] WS_RESET = 4'hf;
    localparam int unsigned A23_BIT = 22;
    localparam int unsigned A20_BIT = 19;
    localparam int unsigned A24_BIT = 23;
    localparam int unsigned SEL0 = 0;
    localparam int unsigned SEL1 = 1;
    localparam int unsigned SEL2 = 2;
    localparam int unsigned SEL4 = 4;
    localparam logic [1:0] PIN_SEL_ONE = 2'h0;
    localparam logic [1:0] PIN_SPI_THREE = 2'h1;
    localparam logic [1:0] PIN_GPIO = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;
    localparam logic [ADDR_W-1:0] ZERO_ADDR = 24'h000000;
    localparam logic [DATA_W-1:0] ZERO_DATA = 16'h0000;
    localparam logic [WS_W-1:0] ZERO_WS = 4'h0;
    localparam logic [WS_W-1:0] ONE_WS = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_WAIT = 3'b010,
        ST_DATA = 3'b011,
        ST_HOLD = 3'b100,
        ST_ERR = 3'b101
    } ecsb_state_t;
endpackage : ecsb_pkg

// File: ecsb_sync_if.sv
// Interface carrying the resynchronised cycle-done event.
// Assumes producer and consumer share the core clock.
`default_nettype none
interface ecsb_sync_if;
    logic done_pulse;
    logic done_level;
    modport prod (output done_pulse, output done_level);
    modport cons (input done_pulse, input done_level);
endinterface : ecsb_sync_if
`default_nettype wire

// File: ecsb_done_sync.sv
// Two-flop synchroniser and falling-edge detector for cycle-done.
// Assumes the input is asynchronous to the core clock.
`default_nettype none
module ecsb_done_sync (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_pin_n,
    ecsb_sync_if.prod sync
);
    logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

    always_comb begin
        s1_d = s1_q;
        s2_d = s2_q;
        s3_d = s3_q;
        if (i_ce) begin
            s1_d = i_pin_n;
            s2_d = s1_q;
            s3_d = s2_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // Edge only: a held-low input gives no second event
    assign sync.done_pulse = s3_q & ~s2_q;
    assign sync.done_level = ~s2_q;
endmodule // ecsb_done_sync
`default_nettype wire

// File: ecsb_bus.sv
// External chip-select bus master: address, strobes, data, bus clock.
// Assumes one request at a time from the core, held until o_DONE.
`default_nettype none

module ecsb_bus import ecsb_pkg::*; (
    // Clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    // Core request
    input wire logic I_REQ,
    input wire logic I_WRITE,
    input wire logic I_LONG,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [2*DATA_W-1:0] I_WDATA,
    input wire logic [NSEL-1:0] I_SEL_HIT,
    input wire logic I_DRAM_HIT,
    input wire logic I_SBC_HIT,
    output logic O_DONE,
    output logic O_BUS_ERR,
    output logic [2*DATA_W-1:0] O_RDATA,
    // Configuration
    input wire logic I_DONE_PIN_EN,
    input wire logic I_INT_TERM,
    input wire logic [WS_W-1:0] I_WAIT_COUNT,
    input wire logic I_CFG_VALID,
    input wire logic [1:0] I_SHARED_PIN_FN,
    // Status
    output logic O_BOOT_EXT,
    // External pins
    output logic O_BCLK,
    output logic [ADDR_W-1:0] O_A,
    output logic O_RW,
    input wire logic [DATA_W-1:0] I_D,
    output logic [DATA_W-1:0] O_D,
    output logic O_D_OE_N,
    output logic O_SELECT_ZERO_N,
    output logic O_SELECT_ONE_N,
    output logic O_SELECT_TWO_N,
    output logic O_SELECT_FOUR_N,
    output logic O_SERIAL_PERIPH_SELECT_THREE_N,
    output logic O_SHARED_GP_PIN_TWENTYEIGHT,
    output logic O_READ_STROBE_N,
    input wire logic I_CYCLE_DONE_IN_N,
    input wire logic I_SDRAM_ACC,
    input wire logic I_SPI_SEL3_N,
    input wire logic I_BOOT_STRAP
);
    // ****************************************
    // Bus clock and pin synchronisers
    // ****************************************
    logic bclk_q, bclk_d;
    logic [1:0] strap_arm_q, strap_arm_d;
    logic [DATA_W-1:0] d_s1_d, d_s2_d;
    logic [DATA_W-1:0] din_s1_q, din_s2_q;
    logic a23_s1_q, a23_s2_q, a23_s1_d, a23_s2_d;
    logic strap_done_q, strap_done_d, boot_ext_q, boot_ext_d;
    logic rise, fall;
    ecsb_sync_if sif ();

    ecsb_done_sync u_sync (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_pin_n(I_CYCLE_DONE_IN_N),
        .sync(sif)
    );

    // Rising bus edge is the core edge where bclk goes high
    assign rise = I_CE & ~bclk_q;
    assign fall = I_CE & bclk_q;

    always_comb begin
        bclk_d = bclk_q;
        d_s1_d = din_s1_q;
        d_s2_d = din_s2_q;
        a23_s1_d = a23_s1_q;
        a23_s2_d = a23_s2_q;
        strap_done_d = strap_done_q;
        boot_ext_d = boot_ext_q;
        strap_arm_d = strap_arm_q;
        if (I_CE) begin
            bclk_d = ~bclk_q;
            d_s1_d = I_D;
            d_s2_d = din_s1_q;
            a23_s1_d = I_BOOT_STRAP;
            a23_s2_d = a23_s1_q;
            strap_arm_d = {strap_arm_q[0], 1'b1};
            // Strap taken after release, once synchronised
            if (strap_arm_q[1] && !strap_done_q) begin
                strap_done_d = 1'b1;
                boot_ext_d = a23_s2_q;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            bclk_q <= 1'b0;
            din_s1_q <= ZERO_DATA;
            din_s2_q <= ZERO_DATA;
            a23_s1_q <= 1'b1;
            a23_s2_q <= 1'b1;
            strap_done_q <= 1'b0;
            strap_arm_q <= 2'h0;
            boot_ext_q <= 1'b1;
        end else begin
            bclk_q <= bclk_d;
            din_s1_q <= d_s1_d;
            din_s2_q <= d_s2_d;
            a23_s1_q <= a23_s1_d;
            a23_s2_q <= a23_s2_d;
            strap_done_q <= strap_done_d;
            strap_arm_q <= strap_arm_d;
            boot_ext_q <= boot_ext_d;
        end
    end

    // ****************************************
    // Cycle state machine
    // ****************************************
    ecsb_state_t st_q, st_d;
    logic [ADDR_W-1:0] a_q, a_d;
    logic rw_q, rw_d;
    logic [DATA_W-1:0] do_q, do_d;
    logic doe_n_q, doe_n_d;
    logic [NSEL-1:0] sel_q, sel_d;
    logic rd_q, rd_d;
    logic [WS_W-1:0] wc_q, wc_d;
    logic second_q, second_d;
    logic [2*DATA_W-1:0] rdat_q, rdat_d;
    logic done_q, done_d, err_q, err_d;
    logic [WS_W-1:0] ws_q, ws_d;
    logic intterm_q, intterm_d, ext_en_q, ext_en_d;
    logic armed_q, armed_d;
    logic hit_any, term_ok;

    assign hit_any = (|I_SEL_HIT) | I_DRAM_HIT | I_SBC_HIT;
    // External termination only from a fresh edge, never for SDRAM
    assign term_ok = intterm_q ? (wc_q == ZERO_WS)
        : (ext_en_q & armed_q & sif.done_pulse
           & ~I_SDRAM_ACC);

    always_comb begin
        st_d = st_q;
        a_d = a_q;
        rw_d = rw_q;
        do_d = do_q;
        doe_n_d = doe_n_q;
        sel_d = sel_q;
        rd_d = rd_q;
        wc_d = wc_q;
        second_d = second_q;
        rdat_d = rdat_q;
        done_d = 1'b0;
        err_d = 1'b0;
        ws_d = ws_q;
        intterm_d = intterm_q;
        ext_en_d = ext_en_q;
        armed_d = armed_q;
        if (I_CFG_VALID && I_CE) begin
            ws_d = I_WAIT_COUNT;
            intterm_d = I_INT_TERM;
            ext_en_d = I_DONE_PIN_EN;
        end
        if (fall) begin
            case (st_q)
                ST_ADDR: begin
                    sel_d = I_SEL_HIT;
                    rd_d = ~rw_q ? 1'b0 : (|(I_SEL_HIT & 5'h17));
                end
                ST_HOLD: begin
                    sel_d = '0;
                    rd_d = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (rise) begin
            case (st_q)
                ST_IDLE: begin
                    if (I_REQ && !done_q && !err_q) begin
                        if (!hit_any) begin
                            st_d = ST_ERR;
                        end else begin
                            a_d = I_ADDR;
                            if (I_SDRAM_ACC) begin
                                a_d[A20_BIT] = I_ADDR[A24_BIT];
                            end
                            rw_d = ~I_WRITE;
                            do_d = I_WDATA[2*DATA_W-1:DATA_W];
                            doe_n_d = ~I_WRITE;
                            second_d = 1'b0;
                            wc_d = ws_q;
                            st_d = ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    armed_d = ~sif.done_level;
                    st_d = ST_WAIT;
                end
                ST_WAIT: begin
                    if (!sif.done_level) begin
                        armed_d = 1'b1;
                    end
                    if (term_ok) begin
                        st_d = ST_DATA;
                    end else if (wc_q != ZERO_WS) begin
                        wc_d = wc_q - ONE_WS;
                    end
                end
                ST_DATA: begin
                    if (rw_q) begin
                        if (second_q) begin
                            rdat_d[DATA_W-1:0] = din_s2_q;
                        end else begin
                            rdat_d[2*DATA_W-1:DATA_W] = din_s2_q;
                        end
                    end
                    st_d = ST_HOLD;
                end
                ST_HOLD: begin
                    if (I_LONG && !second_q) begin
                        second_d = 1'b1;
                        a_d = a_q + ADDR_ONE + ADDR_ONE;
                        do_d = I_WDATA[DATA_W-1:0];
                        wc_d = ws_q;
                        st_d = ST_ADDR;
                    end else begin
                        doe_n_d = 1'b1;
                        done_d = 1'b1;
                        st_d = ST_IDLE;
                    end
                end
                ST_ERR: begin
                    err_d = 1'b1;
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q <= ST_IDLE;
            a_q <= ZERO_ADDR;
            rw_q <= 1'b1;
            do_q <= ZERO_DATA;
            doe_n_q <= 1'b1;
            sel_q <= '0;
            rd_q <= 1'b0;
            wc_q <= WS_RESET;
            second_q <= 1'b0;
            rdat_q <= '0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            ws_q <= WS_RESET;
            intterm_q <= 1'b1;
            ext_en_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            st_q <= st_d;
            a_q <= a_d;
            rw_q <= rw_d;
            do_q <= do_d;
            doe_n_q <= doe_n_d;
            sel_q <= sel_d;
            rd_q <= rd_d;
            wc_q <= wc_d;
            second_q <= second_d;
            rdat_q <= rdat_d;
            done_q <= I_CE ? done_d : done_q;
            err_q <= I_CE ? err_d : err_q;
            ws_q <= ws_d;
            intterm_q <= intterm_d;
            ext_en_q <= ext_en_d;
            armed_q <= armed_d;
        end
    end

    // ****************************************
    // Pin mapping
    // ****************************************
    always_comb begin
        O_BCLK = bclk_q;
        O_A = a_q;
        O_RW = rw_q;
        O_D = do_q;
        O_D_OE_N = doe_n_q;
        O_READ_STROBE_N = ~rd_q;
        O_SELECT_TWO_N = ~sel_q[SEL2];
        // Strap decides whether select zero or select four can go active
        O_SELECT_ZERO_N = ~(sel_q[SEL0] & boot_ext_q);
        O_SELECT_FOUR_N = ~(sel_q[SEL4] & ~boot_ext_q);
        O_SELECT_ONE_N = 1'b1;
        O_SERIAL_PERIPH_SELECT_THREE_N = 1'b1;
        O_SHARED_GP_PIN_TWENTYEIGHT = 1'b0;
        if (I_SHARED_PIN_FN == PIN_SPI_THREE) begin
            O_SERIAL_PERIPH_SELECT_THREE_N = I_SPI_SEL3_N;
        end else if (I_SHARED_PIN_FN == PIN_GPIO) begin
            O_SHARED_GP_PIN_TWENTYEIGHT = 1'b1;
        end else begin
            O_SELECT_ONE_N = ~sel_q[SEL1];
        end
        O_DONE = done_q;
        O_BUS_ERR = err_q;
        O_RDATA = rdat_q;
        O_BOOT_EXT = boot_ext_q;
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence read_start_s;
        rise && st_q == ST_IDLE && I_REQ && !done_q && !err_q && hit_any
            && !I_WRITE;
    endsequence

    bclk_half_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        I_CE |=> bclk_q != $past(bclk_q))
        else $error("bus clock did not toggle");
    miss_err_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (rise && st_q == ST_IDLE && I_REQ && !hit_any && !done_q && !err_q
         && I_CE)
        |=> I_CE [*2] ##1 (O_BUS_ERR && sel_q == '0))
        else $error("miss did not end in error");
    err_nosel_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        O_BUS_ERR |-> sel_q == '0)
        else $error("select during error");
    write_drive_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (st_q == ST_DATA && !rw_q) |-> !O_D_OE_N)
        else $error("write data not driven");
    read_float_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        read_start_s |=> O_D_OE_N && O_RW)
        else $error("read cycle drives data");
    ext_off_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (st_q == ST_WAIT && !ext_en_q && !intterm_q) |=> st_q != ST_DATA)
        else $error("cycle-done used while disabled");
    sdram_nodone_a: assert property (@(posedge I_CLK)
        disable iff (!I_ARST_N)
        (st_q == ST_WAIT && !intterm_q && I_SDRAM_ACC) |=> st_q != ST_DATA)
        else $error("sdram ended by cycle-done");
    strobe_edge_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        $changed(sel_q) |-> $past(bclk_q))
        else $error("select moved off falling edge");
    wait_count_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        (rise && st_q == ST_WAIT && intterm_q && wc_q != ZERO_WS)
        |=> wc_q == $past(wc_q) - ONE_WS)
        else $error("wait count not stepped");
endmodule // ecsb_bus
`default_nettype wire

// File: ecsb_slave_model.sv
// Memory partner on the external select bus, with cycle-done responder.
// Assumes the bench steers the control inputs between bus cycles.
`default_nettype none
module ecsb_slave_model (
    // Bus side
    input wire logic i_bclk,
    input wire logic [23:0] i_a,
    input wire logic i_rw,
    input wire logic [15:0] i_d,
    input wire logic i_sel_n,
    input wire logic i_rd_n,
    // Bench control
    input wire logic i_ack_en,
    input wire logic i_stuck,
    input wire logic [3:0] i_dly,
    // Responses
    output logic [15:0] o_d = 16'h0,
    output logic o_done_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:255];
    int cnt = 0;
    // ****
    // Storage
    // ****
    // Mid-clock capture keeps clear of address edges
    always @(negedge i_bclk) begin
        if (!i_sel_n && !i_rw)
            mem[i_a[8:1]] = i_d;
    end
    // Released bus flips each edge so stale data never passes
    always @(i_bclk) begin
        #2;
        if (!i_sel_n && i_rw && !i_rd_n)
            o_d = mem[i_a[8:1]];
        else
            o_d = ~o_d;
    end
    // ****
    // Cycle-done responder
    // ****
    always @(negedge i_bclk) begin
        #2;
        if (i_stuck)
            o_done_n = 1'b0;
        else if (!i_ack_en || i_sel_n) begin
            o_done_n = 1'b1;
            cnt = 0;
        end else begin
            cnt++;
            o_done_n = (cnt <= int'(i_dly));
        end
    end
endmodule // ecsb_slave_model
`default_nettype wire

// File: ecsb_bus_tb.sv
// Self-checking bench for the external chip-select bus.
// Assumes the package, the design and the memory partner compile first.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ecsb_bus_tb import ecsb_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Signals
    // ****
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req, wr, lng, dram, pin_en, int_term, cfg_v, ack_en, stuck;
    logic [ADDR_W-1:0] addr, a, ad;
    logic [2*DATA_W-1:0] wdata, rdat, got, d;
    logic [NSEL-1:0] hit, seen;
    logic [WS_W-1:0] ws, wsr;
    logic [3:0] dly;
    logic [DATA_W-1:0] dout, m_d, bus_d;
    logic done, berr, bclk, rw, doen, s0, s1, s2, s4, rd_n, done_n;
    logic gd, ge, rds, oes, a20s, b, boot, strap;
    logic [DATA_W-1:0] shad [0:255];
    logic [NSEL-1:0] hits [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
    int seed, nlow, n0, n15, miscompares, n_compared;
    // Wire level from both drivers
    assign bus_d = doen ? m_d : dout;
    always #25 clk = ~clk;
    ecsb_bus i_dut (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_CE(1'b1), .I_REQ(req),
        .I_WRITE(wr), .I_LONG(lng), .I_ADDR(addr), .I_WDATA(wdata),
        .I_SEL_HIT(hit), .I_DRAM_HIT(dram), .I_SBC_HIT(1'b0),
        .O_DONE(done), .O_BUS_ERR(berr), .O_RDATA(rdat),
        .I_DONE_PIN_EN(pin_en), .I_INT_TERM(int_term),
        .I_WAIT_COUNT(ws), .I_CFG_VALID(cfg_v), .I_SHARED_PIN_FN(2'h0),
        .O_BOOT_EXT(boot), .O_BCLK(bclk), .O_A(a), .O_RW(rw), .I_D(bus_d),
        .O_D(dout), .O_D_OE_N(doen), .O_SELECT_ZERO_N(s0),
        .O_SELECT_ONE_N(s1), .O_SELECT_TWO_N(s2), .O_SELECT_FOUR_N(s4),
        .O_SERIAL_PERIPH_SELECT_THREE_N(), .O_SHARED_GP_PIN_TWENTYEIGHT(),
        .O_READ_STROBE_N(rd_n), .I_CYCLE_DONE_IN_N(done_n),
        .I_SDRAM_ACC(dram), .I_SPI_SEL3_N(1'b1), .I_BOOT_STRAP(strap)
    );
    ecsb_slave_model i_mem (
        .i_bclk(bclk), .i_a(a), .i_rw(rw), .i_d(bus_d),
        .i_sel_n(s0 & s1 & s2 & s4), .i_rd_n(rd_n), .i_ack_en(ack_en),
        .i_stuck(stuck), .i_dly(dly), .o_d(m_d), .o_done_n(done_n)
    );
    // ****
    // Helpers
    // ****
    function automatic logic [7:0] ix(input logic [23:0] x);
        return x[8:1];
    endfunction
    // Index kept below 254 so the low word never wraps
    function automatic logic [23:0] raddr();
        logic [7:0] i;
        i = 8'({$random(seed)} % 254);
        return {15'h0, i, 1'b0};
    endfunction
    task automatic summarize();
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cfg(input logic [3:0] w, input logic it, input logic pe);
        @(negedge clk);
        ws = w;
        int_term = it;
        pin_en = pe;
        cfg_v = 1'b1;
        @(negedge clk);
        cfg_v = 1'b0;
    endtask
    // Mid-run reset with a new boot strap level
    task automatic restart(input logic v);
        @(negedge clk);
        arst_n = 1'b0;
        strap = v;
        repeat (6) @(negedge clk);
        `CHK({s0, s1, rd_n, doen}, 4'hf)
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // One request, watched at every falling core edge until done
    task automatic xfer(input logic w, input logic l, input logic [23:0] x,
        input logic [31:0] dw, input logic [4:0] h, input logic dh);
        logic [4:0] sv;
        logic [4:0] psv;
        logic pb;
        logic rwok;
        logic [23:0] pa;
        @(negedge clk);
        wr = w;
        lng = l;
        addr = x;
        wdata = dw;
        hit = h;
        dram = dh;
        req = 1'b1;
        nlow = 0;
        {gd, rds, oes, a20s} = 4'h0;
        rwok = 1'b1;
        seen = 5'h1f;
        pb = bclk;
        pa = a;
        psv = 5'h1f;
        for (int k = 0; k < 600 && !gd; k++) begin
            @(negedge clk);
            sv = {s4, 1'b1, s2, s1, s0};
            if (sv !== psv)
                `CHK({pb, bclk}, 2'b10)
            if (!dh && a !== pa)
                `CHK({pb, bclk}, 2'b01)
            if (sv != 5'h1f) begin
                nlow++;
                if (rw !== !w)
                    rwok = 1'b0;
            end
            seen &= sv;
            rds |= (rd_n === 1'b0);
            oes |= (doen === 1'b0);
            a20s |= (a[A20_BIT] === 1'b1);
            if (done === 1'b1) begin
                gd = 1'b1;
                ge = berr;
                got = rdat;
            end
            pb = bclk;
            pa = a;
            psv = sv;
        end
        req = 1'b0;
        `CHK({gd, oes, rwok}, {1'b1, w, 1'b1})
    endtask
    task automatic rdl(input logic [23:0] x, input logic [4:0] h);
        xfer(1'b0, 1'b1, x, 32'h0, h, 1'b0);
        `CHK(got, {shad[ix(x)], shad[ix(x) + 8'h1]})
        `CHK({ge, rds}, 2'b01)
    endtask
    // ****
    // Watchdog
    // ****
    initial begin
        #2_000_000;
        miscompares++;
        summarize();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        seed = 32'hac18a10f;
        {req, wr, lng, dram, pin_en, cfg_v, ack_en, stuck} = 8'h0;
        int_term = 1'b1;
        strap = 1'b1;
        ws = 4'h0;
        dly = 4'h0;
        addr = 24'h0;
        wdata = 32'h0;
        hit = 5'h0;
        for (int i = 0; i < 256; i++) begin
            shad[i] = 16'($random(seed));
            i_mem.mem[i] = shad[i];
        end
        repeat (6) @(negedge clk);
        `CHK({s0, s1, rd_n, doen}, 4'hf)
        arst_n = 1'b1;
        repeat (4) begin
            b = bclk;
            @(negedge clk);
            `CHK(bclk, ~b)
        end
        // Pin answers at once but is still off after reset
        ack_en = 1'b1;
        xfer(1'b0, 1'b0, raddr(), 32'h0, 5'h02, 1'b0);
        n15 = nlow;
        ack_en = 1'b0;
        cfg(4'h0, 1'b1, 1'b0);
        xfer(1'b0, 1'b0, raddr(), 32'h0, 5'h02, 1'b0);
        n0 = nlow;
        `CHK(n0, 6)
        `CHK(n15 - n0, 30)
        repeat (3) begin
            wsr = 4'($random(seed));
            cfg(wsr, 1'b1, 1'b0);
            xfer(1'b0, 1'b0, raddr(), 32'h0, 5'h02, 1'b0);
            `CHK(nlow - n0, 2 * int'(wsr))
        end
        cfg(4'h1, 1'b1, 1'b0);
        repeat (4) begin
            ad = raddr();
            d = $random(seed);
            xfer(1'b1, 1'b1, ad, d, 5'h02, 1'b0);
            shad[ix(ad)] = d[31:16];
            shad[ix(ad) + 8'h1] = d[15:0];
            `CHK({i_mem.mem[ix(ad)], i_mem.mem[ix(ad) + 8'h1]}, d)
            `CHK(seen, 5'h1d)
            rdl(ad, 5'h02);
        end
        foreach (hits[j]) begin
            // Select four only exists when booting from internal ROM
            if (hits[j][4])
                restart(1'b0);
            rdl(raddr(), hits[j]);
            if (hits[j][1] | hits[j][2])
                `CHK(seen, ~hits[j])
            else
                `CHK({seen, boot}, {~hits[j], ~hits[j][4]})
        end
        xfer(1'b0, 1'b1, raddr(), 32'h0, 5'h00, 1'b0);
        `CHK({ge, seen}, 6'h3f)
        xfer(1'b0, 1'b0, 24'h800000 | raddr(), 32'h0, 5'h00, 1'b1);
        `CHK(a20s, 1'b1)
        // Termination now comes from the partner's cycle-done
        cfg(4'h0, 1'b0, 1'b1);
        ack_en = 1'b1;
        rdl(raddr(), 5'h02);
        xfer(1'b0, 1'b0, raddr(), 32'h0, 5'h02, 1'b0);
        n0 = nlow;
        dly = 4'h4;
        xfer(1'b0, 1'b0, raddr(), 32'h0, 5'h02, 1'b0);
        `CHK(nlow - n0, 8)
        dly = 4'h2;
        ad = raddr();
        stuck = 1'b1;
        fork
            rdl(ad, 5'h02);
            begin
                repeat (40) @(negedge clk);
                `CHK(gd, 1'b0)
                stuck = 1'b0;
            end
        join
        summarize();
    end
endmodule // ecsb_bus_tb
`default_nettype wire
